// ==== core/bp_debug_control.sv ====
// Breakpoint control, general detect, pin steering and branch recording
`timescale 1ns/1ns
module bp_debug_control (
    input  wire logic                      core_clk,
    input  wire logic                      srst,
    input  wire logic                      debug_extensions_bit,
    input  wire logic                      long_mode,
    input  wire logic                      trap_flag,
    input  wire logic                      task_switch,
    input  wire logic                      handler_entry,
    input  wire logic                      status_clear,
    input  wire logic [255:0]              address_comparators,
    input  wire bp_debug_pkg::access_req_t acc,
    input  wire bp_debug_pkg::transfer_t   xfer,
    input  wire logic                      insn_retire,
    input  wire bp_debug_pkg::reg_access_t reg_acc,
    input  wire logic [2:0]                rd_sel,
    input  wire logic [3:0]                perf_info,
    output logic [63:0]                    rd_data,
    output logic                           debug_exception,
    output logic [3:0]                     bp_hits,
    output logic                           single_step_exception,
    output logic                           protection_fault,
    output logic                           invalid_opcode_fault,
    output logic [3:0]                     perf_breakpoint_pin
);
    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [63:0] breakpoint_control;
    logic [63:0] debug_extra_control;
    logic [63:0] last_branch_source;
    logic [63:0] last_branch_target;
    logic [63:0] last_exception_source;
    logic [63:0] last_exception_target;
    logic        access_detected_flag;
    logic [3:0]  raw_hit;
    logic [3:0]  armed_hit;
    logic        gd_trap;
    logic        ext_bad;
    logic        upper_bad;
    logic        ctl_write;
    logic        msr_write;
    logic [63:0] next_control;

    // ****************************************************************
    // Comparators
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_cmp
            bp_comparator u_cmp (
                .debug_extensions_bit (debug_extensions_bit),
                .long_mode            (long_mode),
                .bp_addr              (address_comparators[gi*64 +: 64]),
                .access_type_field    (breakpoint_control[bp_debug_pkg::TYPE_POS + gi*4 +: 2]),
                .match_length_field   (breakpoint_control[bp_debug_pkg::LEN_POS + gi*4 +: 2]),
                .acc                  (acc),
                .hit                  (raw_hit[gi])
            );
            assign armed_hit[gi] = raw_hit[gi]
                && (breakpoint_control[bp_debug_pkg::LOCAL_EN_POS + gi*2]
                    || breakpoint_control[bp_debug_pkg::GLOBAL_EN_POS + gi*2]);
        end
    endgenerate

    // ****************************************************************
    // Register access decode
    // ****************************************************************
    // Registers 8..15 are not implemented
    assign ext_bad   = reg_acc.valid && !reg_acc.msr && reg_acc.dreg[3];
    // Any move of debug registers 0..7 traps when armed
    assign gd_trap   = reg_acc.valid && !reg_acc.msr && !ext_bad
                       && breakpoint_control[bp_debug_pkg::GEN_DETECT_POS];
    // Upper half must be zero in long mode
    assign upper_bad = reg_acc.valid && reg_acc.write && !reg_acc.msr && long_mode
                       && (reg_acc.dreg == 4'h7)
                       && ((reg_acc.wdata & bp_debug_pkg::UPPER_HALF_MASK) != 64'h0);
    assign ctl_write = reg_acc.valid && reg_acc.write && !reg_acc.msr
                       && (reg_acc.dreg == 4'h7) && !gd_trap && !upper_bad;
    assign msr_write = reg_acc.valid && reg_acc.write && reg_acc.msr;

    always_comb begin
        next_control = breakpoint_control;
        if (ctl_write) begin
            next_control = (reg_acc.wdata & bp_debug_pkg::BP_CONTROL_WMASK)
                           | bp_debug_pkg::BP_CONTROL_RESET;
        end
        if (task_switch) begin
            next_control[6] = 1'b0;
            next_control[4] = 1'b0;
            next_control[2] = 1'b0;
            next_control[0] = 1'b0;
        end
        if (handler_entry) begin
            next_control[bp_debug_pkg::GEN_DETECT_POS] = 1'b0;
        end
    end

    // ****************************************************************
    // Control register
    // ****************************************************************
    // Globals only change by software write
    // Legacy bits stored, read nowhere else
    always_ff @(posedge core_clk) begin
        if (srst) begin
            breakpoint_control <= bp_debug_pkg::BP_CONTROL_RESET;
        end else begin
            breakpoint_control <= next_control;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            debug_extra_control <= 64'h0;
        end else if (msr_write) begin
            debug_extra_control <= reg_acc.wdata & bp_debug_pkg::EXTRA_CTRL_WMASK;
        end
    end

    // Set beats a same-cycle clear
    always_ff @(posedge core_clk) begin
        if (srst) begin
            access_detected_flag <= 1'b0;
        end else if (gd_trap) begin
            access_detected_flag <= 1'b1;
        end else if (status_clear) begin
            access_detected_flag <= 1'b0;
        end
    end

    // ****************************************************************
    // Control transfer recording
    // ****************************************************************
    // Capture when recording on
    always_ff @(posedge core_clk) begin
        if (srst) begin
            last_branch_source    <= 64'h0;
            last_branch_target    <= 64'h0;
            last_exception_source <= 64'h0;
            last_exception_target <= 64'h0;
        end else if (xfer.valid && debug_extra_control[bp_debug_pkg::LBR_POS]) begin
            if (xfer.is_exception) begin
                last_exception_source <= xfer.source;
                last_exception_target <= xfer.target;
            end else begin
                last_branch_source <= xfer.source;
                last_branch_target <= xfer.target;
            end
        end
    end

    // ****************************************************************
    // Exceptions and pins
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (srst) begin
            debug_exception       <= 1'b0;
            bp_hits               <= 4'h0;
            protection_fault      <= 1'b0;
            invalid_opcode_fault  <= 1'b0;
            single_step_exception <= 1'b0;
        end else begin
            debug_exception      <= (|armed_hit) || gd_trap;
            bp_hits              <= armed_hit;
            protection_fault     <= upper_bad && !gd_trap;
            invalid_opcode_fault <= ext_bad;
            single_step_exception <= trap_flag && (debug_extra_control[bp_debug_pkg::BRANCH_STEP_POS]
                                                   ? xfer.valid : insn_retire);
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            perf_breakpoint_pin <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                perf_breakpoint_pin[i] <= debug_extra_control[bp_debug_pkg::PIN_SEL_POS + i]
                                          ? raw_hit[i] : perf_info[i];
            end
        end
    end

    // Read port registered; recording registers have no write path
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rd_data <= 64'h0;
        end else begin
            case (rd_sel)
                bp_debug_pkg::SEL_BP_CONTROL: rd_data <= breakpoint_control;
                bp_debug_pkg::SEL_EXTRA_CTRL: rd_data <= debug_extra_control;
                bp_debug_pkg::SEL_BR_SOURCE:  rd_data <= last_branch_source;
                bp_debug_pkg::SEL_BR_TARGET:  rd_data <= last_branch_target;
                bp_debug_pkg::SEL_EXC_SOURCE: rd_data <= last_exception_source;
                bp_debug_pkg::SEL_EXC_TARGET: rd_data <= last_exception_target;
                bp_debug_pkg::SEL_STATUS:
                    rd_data <= {50'h0, access_detected_flag, 13'h0};
                default:                      rd_data <= 64'h0;
            endcase
        end
    end
endmodule : bp_debug_control

// ==== inc/bp_debug_pkg.sv ====
// Package of constants and carriers for the breakpoint debug control block
package bp_debug_pkg;
    // ****************************************************************
    // Register selectors
    // ****************************************************************
    localparam logic [2:0] SEL_BP_CONTROL   = 3'h0;
    localparam logic [2:0] SEL_EXTRA_CTRL   = 3'h1;
    localparam logic [2:0] SEL_BR_SOURCE    = 3'h2;
    localparam logic [2:0] SEL_BR_TARGET    = 3'h3;
    localparam logic [2:0] SEL_EXC_SOURCE   = 3'h4;
    localparam logic [2:0] SEL_EXC_TARGET   = 3'h5;
    localparam logic [2:0] SEL_STATUS       = 3'h6;

    // ****************************************************************
    // Breakpoint control, status and extra control field positions
    // ****************************************************************
    localparam int LOCAL_EN_POS   = 0;
    localparam int GLOBAL_EN_POS  = 1;
    localparam int LEGACY_LE_POS  = 8;
    localparam int LEGACY_GE_POS  = 9;
    localparam int RSVD_ONE_POS   = 10;
    localparam int GEN_DETECT_POS = 13;
    localparam int TYPE_POS       = 16;
    localparam int LEN_POS        = 18;
    localparam int ACCESS_DET_POS = 13;
    localparam int LBR_POS        = 0;
    localparam int BRANCH_STEP_POS = 1;
    localparam int PIN_SEL_POS    = 2;
    localparam logic [63:0] BP_CONTROL_RESET = 64'h0000_0000_0000_0400;
    localparam logic [63:0] BP_CONTROL_WMASK = 64'h0000_0000_FFFF_23FF;
    localparam logic [63:0] EXTRA_CTRL_WMASK = 64'h0000_0000_0000_003F;
    localparam logic [63:0] UPPER_HALF_MASK  = 64'hFFFF_FFFF_0000_0000;

    // ****************************************************************
    // Access types and lengths
    // ****************************************************************
    localparam logic [1:0] TYPE_EXEC  = 2'h0;
    localparam logic [1:0] TYPE_WRITE = 2'h1;
    localparam logic [1:0] TYPE_IO    = 2'h2;
    localparam logic [1:0] TYPE_RW    = 2'h3;
    localparam logic [1:0] LEN_1      = 2'h0;
    localparam logic [1:0] LEN_2      = 2'h1;
    localparam logic [1:0] LEN_8      = 2'h2;
    localparam logic [1:0] LEN_4      = 2'h3;

    typedef enum logic [1:0] {
        ACC_FETCH,
        ACC_READ,
        ACC_WRITE,
        ACC_IO
    } access_kind_t;

    typedef struct packed {
        logic         valid;
        access_kind_t kind;
        logic [63:0]  addr;
        logic [3:0]   size;
    } access_req_t;

    typedef struct packed {
        logic        valid;
        logic        is_exception;
        logic [63:0] source;
        logic [63:0] target;
    } transfer_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic        msr;
        logic [3:0]  dreg;
        logic [63:0] wdata;
    } reg_access_t;
endpackage : bp_debug_pkg

// ==== core/bp_comparator.sv ====
// One address breakpoint comparator
`timescale 1ns/1ns
module bp_comparator (
    input  wire logic                      debug_extensions_bit,
    input  wire logic                      long_mode,
    input  wire logic [63:0]               bp_addr,
    input  wire logic [1:0]                access_type_field,
    input  wire logic [1:0]                match_length_field,
    input  wire bp_debug_pkg::access_req_t acc,
    output logic                           hit
);
    logic [63:0] range_mask;
    logic [63:0] acc_last;
    logic        type_ok;

    always_comb begin
        case (match_length_field)
            bp_debug_pkg::LEN_2: range_mask = 64'hFFFF_FFFF_FFFF_FFFE;
            bp_debug_pkg::LEN_4: range_mask = 64'hFFFF_FFFF_FFFF_FFFC;
            bp_debug_pkg::LEN_8: range_mask = long_mode ? 64'hFFFF_FFFF_FFFF_FFF8
                                                         : 64'hFFFF_FFFF_FFFF_FFFF;
            default:             range_mask = 64'hFFFF_FFFF_FFFF_FFFF;
        endcase
    end

    always_comb begin
        case (access_type_field)
            bp_debug_pkg::TYPE_EXEC:  type_ok = (acc.kind == bp_debug_pkg::ACC_FETCH);
            bp_debug_pkg::TYPE_WRITE: type_ok = (acc.kind == bp_debug_pkg::ACC_WRITE);
            bp_debug_pkg::TYPE_IO:    type_ok = debug_extensions_bit
                                                && (acc.kind == bp_debug_pkg::ACC_IO);
            default:                  type_ok = (acc.kind == bp_debug_pkg::ACC_READ)
                                                || (acc.kind == bp_debug_pkg::ACC_WRITE);
        endcase
    end

    assign acc_last = acc.addr + {60'h0, acc.size} - 64'h1;

    assign hit = acc.valid && type_ok && (acc.size != 4'h0)
                 && ((acc.addr & range_mask) <= (bp_addr & range_mask))
                 && ((acc_last & range_mask) >= (bp_addr & range_mask));
endmodule : bp_comparator

// ==== verif/pipe_model.sv ====
// Pipeline and debug software model for the breakpoint debug control block
`timescale 1ns/1ns
module pipe_model (
    input  wire logic                 core_clk,
    output bp_debug_pkg::access_req_t acc,
    output bp_debug_pkg::transfer_t   xfer,
    output bp_debug_pkg::reg_access_t reg_acc
);
    initial begin
        acc = 71'h0;
        xfer = 130'h0;
        reg_acc = 71'h0;
    end
    // Released fields flip, so a stale value never looks held
    task automatic idle();
        @(posedge core_clk);
        #1;
        acc = {1'b0, ~acc[69:0]};
        xfer = {1'b0, ~xfer[128:0]};
        reg_acc = {1'b0, ~reg_acc[69:0]};
    endtask : idle
    task automatic move(input logic wr, input logic [3:0] dr, input logic [63:0] d);
        @(posedge core_clk);
        #1;
        reg_acc = {1'b1, wr, 1'b0, dr, (dr == 4'h7) ? (d | 64'h400) & ~64'hD800 : d};
        idle();
    endtask : move
    task automatic msr(input logic [63:0] d);
        @(posedge core_clk);
        #1;
        reg_acc = {3'h7, 4'h0, d};
        idle();
    endtask : msr
    task automatic access(input bp_debug_pkg::access_kind_t k, input logic [63:0] a,
                          input logic [3:0] sz);
        @(posedge core_clk);
        #1;
        acc = {1'b1, k, a, sz};
        idle();
    endtask : access
    task automatic transfer(input logic ex, input logic [63:0] s, input logic [63:0] t);
        @(posedge core_clk);
        #1;
        xfer = {1'b1, ex, s, t};
        idle();
    endtask : transfer
endmodule : pipe_model

// ==== verif/bp_debug_control_chk.sv ====
// Port assertions for the breakpoint debug control block
`timescale 1ns/1ns
module bp_debug_control_chk (
    input wire logic                      core_clk,
    input wire logic                      srst,
    input wire logic                      long_mode,
    input wire logic                      trap_flag,
    input wire logic                      insn_retire,
    input wire bp_debug_pkg::access_req_t acc,
    input wire bp_debug_pkg::transfer_t   xfer,
    input wire bp_debug_pkg::reg_access_t reg_acc,
    input wire logic [2:0]                rd_sel,
    input wire logic [63:0]               rd_data,
    input wire logic                      debug_exception,
    input wire logic [3:0]                bp_hits,
    input wire logic                      single_step_exception,
    input wire logic                      protection_fault,
    input wire logic                      invalid_opcode_fault
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    a_ext_reg_fault: assert property (reg_acc.valid && !reg_acc.msr
        && reg_acc.dreg[3] |=> invalid_opcode_fault) else $error("no invalid opcode");
    a_upper_refused: assert property (reg_acc.valid && reg_acc.write
        && !reg_acc.msr && reg_acc.dreg == 4'h7 && long_mode && reg_acc.wdata[63:32] != 32'h0
        |=> protection_fault || debug_exception) else $error("upper write not refused");
    a_hit_raises: assert property (bp_hits != 4'h0 |-> debug_exception)
        else $error("hit without exception");
    a_step_cause: assert property (single_step_exception
        |-> $past(trap_flag && (xfer.valid || insn_retire))) else $error("stray step");
    a_exc_cause: assert property (debug_exception
        |-> $past(acc.valid || (reg_acc.valid && !reg_acc.msr))) else $error("stray exception");
    a_ctrl_fixed: assert property (rd_sel == bp_debug_pkg::SEL_BP_CONTROL
        |=> rd_data[15:14] == 2'h0 && rd_data[12:10] == 3'h1 && rd_data[63:32] == 32'h0)
        else $error("reserved control bits wrong");
    a_status_only: assert property (rd_sel == bp_debug_pkg::SEL_STATUS
        |=> rd_data[63:14] == 50'h0 && rd_data[12:0] == 13'h0) else $error("status bits wrong");
    a_extra_rsvd: assert property (rd_sel == bp_debug_pkg::SEL_EXTRA_CTRL
        |=> rd_data[63:6] == 58'h0) else $error("extra control reserved bits set");
    c_exc: cover property (debug_exception);
    c_fault: cover property (protection_fault);
    c_step: cover property (single_step_exception);
endmodule : bp_debug_control_chk
bind bp_debug_control bp_debug_control_chk u_bp_debug_control_chk (
    .core_clk(core_clk), .srst(srst), .long_mode(long_mode), .trap_flag(trap_flag),
    .insn_retire(insn_retire), .acc(acc), .xfer(xfer), .reg_acc(reg_acc), .rd_sel(rd_sel),
    .rd_data(rd_data), .debug_exception(debug_exception), .bp_hits(bp_hits),
    .single_step_exception(single_step_exception), .protection_fault(protection_fault),
    .invalid_opcode_fault(invalid_opcode_fault));

// ==== verif/tb_bp_debug_control.sv ====
// Self-checking bench for the breakpoint debug control block
`timescale 1ns/1ns
module tb_bp_debug_control;
    logic                      core_clk = 1'b0;
    logic                      srst = 1'b1;
    logic                      debug_extensions_bit = 1'b1;
    logic                      long_mode = 1'b0;
    logic                      trap_flag = 1'b0;
    logic [3:0]                pulses = 4'h0;
    logic [255:0]              address_comparators = 256'h0;
    logic [2:0]                rd_sel = 3'h0;
    logic [3:0]                perf_info = 4'h0;
    logic [63:0]               rd_data;
    logic                      debug_exception;
    logic [3:0]                bp_hits;
    logic                      single_step_exception;
    logic                      protection_fault;
    logic                      invalid_opcode_fault;
    logic [3:0]                perf_breakpoint_pin;
    bp_debug_pkg::access_req_t acc;
    bp_debug_pkg::transfer_t   xfer;
    bp_debug_pkg::reg_access_t reg_acc;
    int                        bad_count = 0;
    int                        tests_run = 0;
    int                        cycles = 0;
    always #25 core_clk = ~core_clk;
    pipe_model u_pipe_model (.core_clk(core_clk), .acc(acc), .xfer(xfer), .reg_acc(reg_acc));
    bp_debug_control u_bp_debug_control (
        .core_clk(core_clk), .srst(srst), .debug_extensions_bit(debug_extensions_bit),
        .long_mode(long_mode), .trap_flag(trap_flag), .task_switch(pulses[0]),
        .handler_entry(pulses[1]), .status_clear(pulses[2]), .insn_retire(pulses[3]),
        .address_comparators(address_comparators), .acc(acc), .xfer(xfer),
        .reg_acc(reg_acc), .rd_sel(rd_sel), .perf_info(perf_info), .rd_data(rd_data),
        .debug_exception(debug_exception), .bp_hits(bp_hits),
        .single_step_exception(single_step_exception), .protection_fault(protection_fault),
        .invalid_opcode_fault(invalid_opcode_fault), .perf_breakpoint_pin(perf_breakpoint_pin));
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic chk_rd(input logic [2:0] sel, input logic [63:0] exp);
        @(posedge core_clk);
        #1;
        rd_sel = sel;
        @(posedge core_clk);
        #1;
        check($sformatf("reg%0d", sel), rd_data, exp);
    endtask : chk_rd
    task automatic pulse(input int i);
        @(posedge core_clk);
        #1;
        pulses[i] = 1'b1;
        @(posedge core_clk);
        #1;
        pulses = 4'h0;
    endtask : pulse
    task automatic probe(input logic [63:0] a, input logic [3:0] sz, input logic [3:0] exp);
        u_pipe_model.access(bp_debug_pkg::ACC_READ, a, sz);
        check("range", {60'h0, bp_hits}, {60'h0, exp});
    endtask : probe
    task automatic t_ctrl();
        chk_rd(bp_debug_pkg::SEL_BP_CONTROL, 64'h400);
        u_pipe_model.move(1'b1, 4'h7, 64'hFFFF_FFFF_FFFF_DBFF);
        chk_rd(bp_debug_pkg::SEL_BP_CONTROL, 64'hFFFF_07FF);
    endtask : t_ctrl
    task automatic t_types();
        logic exp;
        address_comparators[63:0] = 64'hF000;
        for (int t = 0; t < 4; t++) begin
            u_pipe_model.move(1'b1, 4'h7, 64'(t) << 16 | 64'h1);
            for (int k = 0; k < 4; k++) begin
                u_pipe_model.access(bp_debug_pkg::access_kind_t'(k), 64'hF000, 4'h1);
                exp = (t == 0 && k == 0) || (t == 1 && k == 2) || (t == 2 && k == 3)
                    || (t == 3 && (k == 1 || k == 2));
                check("type", {bp_hits, debug_exception}, {3'h0, exp, exp});
            end
        end
        debug_extensions_bit = 1'b0;
        u_pipe_model.move(1'b1, 4'h7, 64'h2_0001);
        u_pipe_model.access(bp_debug_pkg::ACC_IO, 64'hF000, 4'h1);
        check("io_off", {63'h0, debug_exception}, 64'h0);
    endtask : t_types
    task automatic t_length();
        address_comparators[127:64] = 64'hF004;
        address_comparators[255:192] = 64'hF000;
        long_mode = 1'b1;
        u_pipe_model.move(1'b1, 4'h7, 64'hB0F0_0084);
        probe(64'hEFFE, 4'h4, 4'h8);
        probe(64'hF005, 4'h4, 4'hA);
        probe(64'hF000, 4'h1, 4'h8);
        probe(64'hEFFE, 4'h2, 4'h0);
        probe(64'hF003, 4'h2, 4'hA);
    endtask : t_length
    task automatic t_detect();
        u_pipe_model.move(1'b1, 4'h7, 64'hFF);
        pulse(0);
        chk_rd(bp_debug_pkg::SEL_BP_CONTROL, 64'h4AA);
        u_pipe_model.move(1'b1, 4'h7, 64'h2000);
        u_pipe_model.move(1'b0, 4'h0, 64'h0);
        check("gd_exc", {63'h0, debug_exception}, 64'h1);
        chk_rd(bp_debug_pkg::SEL_STATUS, 64'h2000);
        u_pipe_model.move(1'b1, 4'h7, 64'h0);
        chk_rd(bp_debug_pkg::SEL_BP_CONTROL, 64'h2400);
        pulse(1);
        chk_rd(bp_debug_pkg::SEL_BP_CONTROL, 64'h400);
        pulse(2);
        chk_rd(bp_debug_pkg::SEL_STATUS, 64'h0);
        u_pipe_model.move(1'b1, 4'h7, 64'h1_0000_0001);
        check("pf", {63'h0, protection_fault}, 64'h1);
        chk_rd(bp_debug_pkg::SEL_BP_CONTROL, 64'h400);
        for (int r = 8; r < 16; r += 7) begin
            u_pipe_model.move(1'b0, 4'(r), 64'h0);
            check("ud", {63'h0, invalid_opcode_fault}, 64'h1);
        end
    endtask : t_detect
    task automatic t_record();
        u_pipe_model.msr(64'h1);
        u_pipe_model.transfer(1'b0, 64'h1000_00A0, 64'h2000_00B0);
        chk_rd(bp_debug_pkg::SEL_BR_SOURCE, 64'h1000_00A0);
        chk_rd(bp_debug_pkg::SEL_BR_TARGET, 64'h2000_00B0);
        u_pipe_model.transfer(1'b1, 64'h3000_00C0, 64'h4000_00D0);
        u_pipe_model.msr(64'h0);
        u_pipe_model.transfer(1'b1, 64'h5000_00E0, 64'h6000_00F0);
        chk_rd(bp_debug_pkg::SEL_EXC_SOURCE, 64'h3000_00C0);
        chk_rd(bp_debug_pkg::SEL_EXC_TARGET, 64'h4000_00D0);
    endtask : t_record
    task automatic t_step();
        trap_flag = 1'b1;
        pulse(3);
        check("step", {63'h0, single_step_exception}, 64'h1);
        u_pipe_model.msr(64'h2);
        pulse(3);
        check("step", {63'h0, single_step_exception}, 64'h0);
        u_pipe_model.transfer(1'b0, 64'h0, 64'h0);
        check("step", {63'h0, single_step_exception}, 64'h1);
        trap_flag = 1'b0;
        perf_info = 4'hA;
        chk_rd(bp_debug_pkg::SEL_EXTRA_CTRL, 64'h2);
        check("pins", {60'h0, perf_breakpoint_pin}, 64'hA);
        u_pipe_model.msr(64'h3C);
        chk_rd(bp_debug_pkg::SEL_EXTRA_CTRL, 64'h3C);
        check("pins", {60'h0, perf_breakpoint_pin}, 64'h0);
        u_pipe_model.access(bp_debug_pkg::ACC_FETCH, 64'hF000, 4'h1);
        check("pins_bp", {60'h0, perf_breakpoint_pin}, 64'h9);
        check("unarmed", {63'h0, debug_exception}, 64'h0);
    endtask : t_step
    // Cuts a hang short
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            bad_count++;
            end_of_test();
        end
    end
    initial begin
        repeat (2) @(posedge core_clk);
        #1;
        srst = 1'b0;
        t_ctrl();
        t_types();
        t_length();
        t_detect();
        t_record();
        t_step();
        end_of_test();
    end
endmodule : tb_bp_debug_control
